// File: tb/ttcr_checker.sv
// checker: port properties of the timer
`timescale 1ns/1ps
module ttcr_checker
	import ttcr_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins and pulses
	input wire logic        count_input_pin,
	input wire logic        trigger_input_pin,
	input wire logic        port0_tx_baud,
	input wire logic        port0_rx_baud,
	input wire logic        port1_tx_baud,
	input wire logic        port1_rx_baud,
	input wire logic        overflow_pulse
);
	// ----------------------------------------------------------------
	// shadow of the select bits, taken from completed writes
	// ----------------------------------------------------------------
	logic [7:0] ctl_q;
	logic [7:0] pwr_q;
	wire        wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= TTCR_CONTROL_RST;
			pwr_q <= TTCR_PWRCTL_RST;
		end else if (wr_ok && paddr == TTCR_OFS_CONTROL) begin
			ctl_q <= pwdata[7:0];
		end else if (wr_ok && paddr == TTCR_OFS_PWRCTL) begin
			pwr_q <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	ready_wait_a: assert property (psel && penable && !pready && clk_en ##1 clk_en |-> pready)
		else $error("no answer");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	err_unmapped_a: assert property (psel && penable && !pready && paddr > TTCR_OFS_STATUS
		|=> !pready || pslverr) else $error("no pslverr");
	// one cycle of settling after a select write
	tx0_baud_a: assert property (ctl_q[TTCR_CTL_TX_SEL] && $past(ctl_q[TTCR_CTL_TX_SEL])
		|-> port0_tx_baud == overflow_pulse) else $error("tx0 baud");
	rx0_baud_a: assert property (ctl_q[TTCR_CTL_RX_SEL] && $past(ctl_q[TTCR_CTL_RX_SEL])
		|-> port0_rx_baud == overflow_pulse) else $error("rx0 baud");
	tx1_baud_a: assert property (pwr_q[TTCR_PWR_TX1_SEL] && $past(pwr_q[TTCR_PWR_TX1_SEL])
		|-> port1_tx_baud == overflow_pulse) else $error("tx1 baud");
	rx1_baud_a: assert property (pwr_q[TTCR_PWR_RX1_SEL] && $past(pwr_q[TTCR_PWR_RX1_SEL])
		|-> port1_rx_baud == overflow_pulse) else $error("rx1 baud");
	ovf_gap_a: assert property (overflow_pulse |=> !overflow_pulse [*3])
		else $error("overflow too close");
	run_stop_a: assert property (!ctl_q[TTCR_CTL_RUN] [*3] |-> !overflow_pulse)
		else $error("overflow while stopped");
endmodule : ttcr_checker
bind ttcr_top ttcr_checker ttcr_checker_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.count_input_pin(count_input_pin), .trigger_input_pin(trigger_input_pin),
	.port0_tx_baud(port0_tx_baud), .port0_rx_baud(port0_rx_baud),
	.port1_tx_baud(port1_tx_baud), .port1_rx_baud(port1_rx_baud),
	.overflow_pulse(overflow_pulse));

// File: tb/ttcr_pin_model.sv
// partner: drives the count and trigger pins
`timescale 1ns/1ps
module ttcr_pin_model (
	// clock
	input  wire logic pclk,
	// pins
	output logic      count_input_pin,
	output logic      trigger_input_pin
);
	initial begin
		count_input_pin   = 1'b1;
		trigger_input_pin = 1'b1;
	end
	// 12 clocks low, 12 high: pin events no faster than clock/24
	task automatic pulse(input logic trig);
		repeat (2) begin
			@(posedge pclk);
			if (trig)
				trigger_input_pin <= ~trigger_input_pin;
			else
				count_input_pin <= ~count_input_pin;
			repeat (11) @(posedge pclk);
		end
	endtask : pulse
endmodule : ttcr_pin_model

// File: tb/ttcr_tb_top.sv
// testbench: register, timer, baud and pin scenarios
`timescale 1ns/1ps
module ttcr_tb_top;
	import ttcr_pkg::*;
	localparam logic [31:0] RUN = 32'h1 << TTCR_CTL_RUN;
	localparam logic [31:0] CNT = 32'h1 << TTCR_CTL_CNT_SEL;
	localparam logic [31:0] CAP = 32'h1 << TTCR_CTL_CAP_SEL;
	localparam logic [31:0] TEN = 32'h1 << TTCR_CTL_TRIG_EN;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        clk_en  = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [3:0]  pstrb   = 4'h3;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, rerr, ovf, tx0, rx0, tx1, rx1, cnt_pin, trg_pin;
	int          mismatches = 0;
	int          comparisons = 0;
	always #5 pclk = ~pclk;
	ttcr_top ttcr_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .count_input_pin(cnt_pin),
		.trigger_input_pin(trg_pin), .port0_tx_baud(tx0), .port0_rx_baud(rx0),
		.port1_tx_baud(tx1), .port1_rx_baud(rx1), .overflow_pulse(ovf));
	ttcr_pin_model ttcr_pin_model_i (.pclk(pclk), .count_input_pin(cnt_pin),
		.trigger_input_pin(trg_pin));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check("pready", {31'h0, pready}, 32'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rdat, exp);
	endtask : rd_chk
	task automatic wait_ovf(output time t);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (ovf !== 1'b1 && n < 1000);
		check("overflow", {31'h0, ovf}, 32'h1);
		t = $time;
	endtask : wait_ovf
	task automatic ovf_period();
		time t1, t2;
		wait_ovf(t1);
		wait_ovf(t2);
		check("period", 32'((t2 - t1) / 10), 32'(16 * TTCR_TICK_DIV));
	endtask : ovf_period
	task automatic t_regs();
		rd_chk("control", TTCR_OFS_CONTROL, {24'h0, TTCR_CONTROL_RST});
		rd_chk("power", TTCR_OFS_PWRCTL, {24'h0, TTCR_PWRCTL_RST});
		rd_chk("count", TTCR_OFS_COUNT, {16'h0, TTCR_COUNT_RST});
		rd_chk("reload", TTCR_OFS_RELOAD, {16'h0, TTCR_RELOAD_RST});
		rd_chk("status", TTCR_OFS_STATUS, 32'h0000_000C);
		rd_chk("unmapped", 8'h14, 32'h0000_0000);
		check("unmapped err", {31'h0, rerr}, 32'h1);
		$display("test regs done");
	endtask : t_regs
	task automatic t_timer();
		apb(1'b1, TTCR_OFS_RELOAD, 32'h0000_FFF0);
		apb(1'b1, TTCR_OFS_COUNT, 32'h0000_FFFE);
		apb(1'b1, TTCR_OFS_CONTROL, RUN);
		ovf_period();
		rd_chk("overflow flag", TTCR_OFS_CONTROL, RUN | (32'h1 << TTCR_CTL_OVF_FLAG));
		apb(1'b1, TTCR_OFS_CONTROL, 32'h0);
		apb(1'b1, TTCR_OFS_COUNT, 32'h0000_4321);
		repeat (40) @(posedge pclk);
		rd_chk("stopped count", TTCR_OFS_COUNT, 32'h0000_4321);
		$display("test timer done");
	endtask : t_timer
	task automatic t_baud();
		// start near the top so the first overflow comes within the wait limit
		apb(1'b1, TTCR_OFS_COUNT, 32'h0000_FFFE);
		apb(1'b1, TTCR_OFS_PWRCTL, (32'h1 << TTCR_PWR_TX1_SEL) | (32'h1 << TTCR_PWR_RX1_SEL));
		apb(1'b1, TTCR_OFS_CONTROL, RUN | CAP | (32'h3 << TTCR_CTL_TX_SEL));
		ovf_period();
		check("port0 tx baud", {31'h0, tx0}, 32'h1);
		check("port0 rx baud", {31'h0, rx0}, 32'h1);
		check("port1 tx baud", {31'h0, tx1}, 32'h1);
		check("port1 rx baud", {31'h0, rx1}, 32'h1);
		apb(1'b1, TTCR_OFS_CONTROL, 32'h0);
		apb(1'b1, TTCR_OFS_PWRCTL, 32'h0);
		$display("test baud done");
	endtask : t_baud
	task automatic t_capture();
		apb(1'b1, TTCR_OFS_RELOAD, 32'h0);
		apb(1'b1, TTCR_OFS_COUNT, 32'h0000_1234);
		apb(1'b1, TTCR_OFS_CONTROL, RUN | CNT | CAP);
		ttcr_pin_model_i.pulse(1'b1);
		rd_chk("ignored trigger", TTCR_OFS_RELOAD, 32'h0);
		apb(1'b1, TTCR_OFS_CONTROL, RUN | CNT | CAP | TEN);
		ttcr_pin_model_i.pulse(1'b1);
		rd_chk("captured", TTCR_OFS_RELOAD, 32'h0000_1234);
		repeat (3) ttcr_pin_model_i.pulse(1'b0);
		rd_chk("pin count", TTCR_OFS_COUNT, 32'h0000_1237);
		$display("test capture done");
	endtask : t_capture
	task automatic t_reload();
		apb(1'b1, TTCR_OFS_RELOAD, 32'h0000_00AB);
		apb(1'b1, TTCR_OFS_COUNT, 32'h0000_5555);
		apb(1'b1, TTCR_OFS_CONTROL, RUN | CNT | TEN);
		ttcr_pin_model_i.pulse(1'b1);
		rd_chk("trigger reload", TTCR_OFS_COUNT, 32'h0000_00AB);
		rd_chk("trigger flag", TTCR_OFS_CONTROL, RUN | CNT | TEN | (32'h1 << TTCR_CTL_TRIG_FLAG));
		apb(1'b1, TTCR_OFS_COUNT, 32'h0000_FFFF);
		ttcr_pin_model_i.pulse(1'b0);
		rd_chk("overflow reload", TTCR_OFS_COUNT, 32'h0000_00AB);
		$display("test reload done");
	endtask : t_reload
	task automatic t_freeze();
		apb(1'b1, TTCR_OFS_CONTROL, RUN | CNT);
		apb(1'b1, TTCR_OFS_COUNT, 32'h0);
		@(posedge pclk);
		clk_en <= 1'b0;
		// pin events while frozen must leave no trace
		repeat (2) ttcr_pin_model_i.pulse(1'b0);
		@(posedge pclk);
		clk_en <= 1'b1;
		rd_chk("frozen count", TTCR_OFS_COUNT, 32'h0);
		ttcr_pin_model_i.pulse(1'b0);
		rd_chk("count after freeze", TTCR_OFS_COUNT, 32'h0000_0001);
		$display("test freeze done");
	endtask : t_freeze
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	initial begin
		#200_000;
		mismatches++;
		test_done();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_timer();
		t_baud();
		t_capture();
		t_reload();
		t_freeze();
		test_done();
	end
endmodule : ttcr_tb_top

// File: verilog/ttcr_pin_sync.sv
// pin synchroniser with falling-edge detector
`timescale 1ns/1ps
module ttcr_pin_sync (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	// pin
	input  wire logic pin_async,
	// result
	output logic      pin_level,
	output logic      pin_fall
);
	import ttcr_pkg::*;

	logic [TTCR_SYNC_LEN-1:0] sync_q;
	logic                     level_q;

	// --------------------------------------------------------------
	// stages: first flop feeds only the second
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q  <= '1;
			level_q <= 1'b1;
		end else if (clk_en) begin
			sync_q <= {sync_q[TTCR_SYNC_LEN-2:0], pin_async};
			if (sync_q[1] == sync_q[2])
				level_q <= sync_q[2];
		end
	end

	// a falling edge is seen once: accepted level went high to low
	assign pin_level = level_q;
	assign pin_fall  = clk_en && level_q && (sync_q[1] == sync_q[2]) && !sync_q[2];

endmodule : ttcr_pin_sync

// File: verilog/ttcr_pkg.sv
// package: register map, field positions, reset values and timing for the timer
package ttcr_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] TTCR_OFS_CONTROL  = 8'h00;
	localparam logic [7:0] TTCR_OFS_PWRCTL   = 8'h04;
	localparam logic [7:0] TTCR_OFS_COUNT    = 8'h08;
	localparam logic [7:0] TTCR_OFS_RELOAD   = 8'h0C;
	localparam logic [7:0] TTCR_OFS_STATUS   = 8'h10;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int TTCR_CTL_OVF_FLAG     = 7;
	localparam int TTCR_CTL_TRIG_FLAG    = 6;
	localparam int TTCR_CTL_RX_SEL       = 5;
	localparam int TTCR_CTL_TX_SEL       = 4;
	localparam int TTCR_CTL_TRIG_EN      = 3;
	localparam int TTCR_CTL_RUN          = 2;
	localparam int TTCR_CTL_CNT_SEL      = 1;
	localparam int TTCR_CTL_CAP_SEL      = 0;

	// power control register fields (serial port one selects)
	localparam int TTCR_PWR_RX1_SEL      = 5;
	localparam int TTCR_PWR_TX1_SEL      = 4;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  TTCR_CONTROL_RST = 8'h00;
	localparam logic [7:0]  TTCR_PWRCTL_RST  = 8'h00;
	localparam logic [15:0] TTCR_COUNT_RST   = 16'h0000;
	localparam logic [15:0] TTCR_RELOAD_RST  = 16'h0000;

	// ----------------------------------------------------------------
	// timing: timer tick is clock/12, count pin sampled every clock
	// ----------------------------------------------------------------
	localparam int TTCR_TICK_DIV  = 12;
	localparam int TTCR_SYNC_LEN  = 3;

endpackage : ttcr_pkg

// File: verilog/ttcr_top.sv
// top: 16-bit capture/reload timer with APB register slave
//
// Overview of operation
// - tx select routes overflow to port0 tx
// - trigger enable gates trigger falling edges
// - run bit starts and stops counting
// - select internal ticks or count pin events
// - capture on trigger fall when capture selected
// - reload on overflow, also on trigger fall, unless capture selected
// - baud selects force auto-reload on overflow
// - power register selects port1 baud clocks
// - overflow loads reload pair into count, except in capture mode (count wraps to zero)
// - timer at clock/12, pin at most clock/4
// - capture copies count into reload pair
// - capture without trigger: plain up-counter
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ttcr_top (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pins
	input  wire logic        count_input_pin,
	input  wire logic        trigger_input_pin,
	// baud clock pulses to the serial ports
	output logic             port0_tx_baud,
	output logic             port0_rx_baud,
	output logic             port1_tx_baud,
	output logic             port1_rx_baud,
	// status
	output logic             overflow_pulse
);
	import ttcr_pkg::*;

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [7:0]  ctl_q;
	logic [7:0]  ctl_d;
	logic [7:0]  pwr_q;
	logic [7:0]  pwr_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [15:0] rld_q;
	logic [15:0] rld_d;
	logic [3:0]  div_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        p0_tx_q;
	logic        p0_rx_q;
	logic        p1_tx_q;
	logic        p1_rx_q;
	logic        ovf_q;
	logic [7:0]  t1_div_q;

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	logic cnt_level;
	logic cnt_fall;
	logic trg_level;
	logic trg_fall;

	ttcr_pin_sync u_cnt_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.pin_async (count_input_pin),
		.pin_level (cnt_level),
		.pin_fall  (cnt_fall)
	);

	ttcr_pin_sync u_trg_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.pin_async (trigger_input_pin),
		.pin_level (trg_level),
		.pin_fall  (trg_fall)
	);

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [7:0] ttcr_merge(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic en);
		ttcr_merge = en ? new_v : old_v;
	endfunction : ttcr_merge

	function automatic logic [7:0] ttcr_lane(input logic [31:0] w, input int idx);
		ttcr_lane = w[idx*8 +: 8];
	endfunction : ttcr_lane

	// --------------------------------------------------------------
	// apb decode: one-wait answer, pready one cycle after access starts
	// --------------------------------------------------------------
	wire acc_phase = psel && penable && !pready_q;
	wire wr_fire   = psel && penable && pready_q && pwrite;
	wire hit_ctl   = (paddr == TTCR_OFS_CONTROL);
	wire hit_pwr   = (paddr == TTCR_OFS_PWRCTL);
	wire hit_cnt   = (paddr == TTCR_OFS_COUNT);
	wire hit_rld   = (paddr == TTCR_OFS_RELOAD);
	wire hit_sts   = (paddr == TTCR_OFS_STATUS);
	wire mapped    = hit_ctl || hit_pwr || hit_cnt || hit_rld || hit_sts;

	logic [31:0] rd_mux;
	always_comb begin
		if (hit_ctl)
			rd_mux = {24'h00_0000, ctl_q};
		else if (hit_pwr)
			rd_mux = {24'h00_0000, pwr_q};
		else if (hit_cnt)
			rd_mux = {16'h0000, cnt_q};
		else if (hit_rld)
			rd_mux = {16'h0000, rld_q};
		else if (hit_sts)
			rd_mux = {28'h000_0000, trg_level, cnt_level, ovf_q, ctl_q[TTCR_CTL_RUN]};
		else
			rd_mux = 32'h0000_0000;
	end

	// --------------------------------------------------------------
	// mode decode
	// --------------------------------------------------------------
	wire baud_mode  = ctl_q[TTCR_CTL_RX_SEL] || ctl_q[TTCR_CTL_TX_SEL]
		|| pwr_q[TTCR_PWR_RX1_SEL] || pwr_q[TTCR_PWR_TX1_SEL];
	wire capture    = ctl_q[TTCR_CTL_CAP_SEL] && !baud_mode;
	wire trig_ok    = ctl_q[TTCR_CTL_TRIG_EN] && trg_fall;
	wire running    = ctl_q[TTCR_CTL_RUN];
	wire tick_int   = (div_q == 4'(TTCR_TICK_DIV - 1));
	// pin sampling through 3 flops plus edge compare caps rate at clock/4 (each level held 2 clocks)
	wire tick       = ctl_q[TTCR_CTL_CNT_SEL] ? cnt_fall : tick_int;
	wire inc        = clk_en && running && tick;
	wire overflow   = inc && (cnt_q == 16'hFFFF);
	wire do_reload  = !capture && (overflow || (clk_en && trig_ok));
	wire do_capture = capture && clk_en && trig_ok;

	// timer one stand-in for port0 baud when tx/rx select low
	wire t1_tick    = clk_en && (t1_div_q == 8'hFF);

	// --------------------------------------------------------------
	// next-state logic
	// --------------------------------------------------------------
	always_comb begin
		ctl_d = ctl_q;
		pwr_d = pwr_q;
		rld_d = rld_q;
		cnt_d = cnt_q;
		if (inc)
			cnt_d = cnt_q + 16'h0001;
		if (do_reload)
			cnt_d = rld_q;
		if (do_capture)
			rld_d = cnt_q;
		if (wr_fire && hit_ctl)
			ctl_d = ttcr_merge(ctl_q, ttcr_lane(pwdata, 0), pstrb[0]);
		if (wr_fire && hit_pwr)
			pwr_d = ttcr_merge(pwr_q, ttcr_lane(pwdata, 0), pstrb[0]);
		if (wr_fire && hit_cnt) begin
			cnt_d[7:0]  = ttcr_merge(cnt_d[7:0], ttcr_lane(pwdata, 0), pstrb[0]);
			cnt_d[15:8] = ttcr_merge(cnt_d[15:8], ttcr_lane(pwdata, 1), pstrb[1]);
		end
		if (wr_fire && hit_rld) begin
			rld_d[7:0]  = ttcr_merge(rld_d[7:0], ttcr_lane(pwdata, 0), pstrb[0]);
			rld_d[15:8] = ttcr_merge(rld_d[15:8], ttcr_lane(pwdata, 1), pstrb[1]);
		end
		// hardware set wins over a software clear in the same cycle
		if (overflow && !baud_mode)
			ctl_d[TTCR_CTL_OVF_FLAG] = 1'b1;
		if (clk_en && trig_ok)
			ctl_d[TTCR_CTL_TRIG_FLAG] = 1'b1;
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= TTCR_CONTROL_RST;
			pwr_q <= TTCR_PWRCTL_RST;
			cnt_q <= TTCR_COUNT_RST;
			rld_q <= TTCR_RELOAD_RST;
		end else if (clk_en) begin
			ctl_q <= ctl_d;
			pwr_q <= pwr_d;
			cnt_q <= cnt_d;
			rld_q <= rld_d;
		end
	end

	// prescaler only advances while running, so a restart begins a fresh tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_q <= 4'h0;
		else if (clk_en && (!running || tick_int))
			div_q <= 4'h0;
		else if (clk_en)
			div_q <= div_q + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t1_div_q <= 8'h00;
		else if (clk_en)
			t1_div_q <= t1_div_q + 8'h01;
	end

	// --------------------------------------------------------------
	// apb answer
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready_q  <= acc_phase;
			pslverr_q <= acc_phase && !mapped;
			prdata_q  <= (acc_phase && !pwrite) ? rd_mux : 32'h0000_0000;
		end else begin
			// read data never outlives its pready
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
	end

	// --------------------------------------------------------------
	// baud pulses
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p0_tx_q <= 1'b0;
			p0_rx_q <= 1'b0;
			p1_tx_q <= 1'b0;
			p1_rx_q <= 1'b0;
			ovf_q   <= 1'b0;
		end else if (clk_en) begin
			p0_tx_q <= ctl_q[TTCR_CTL_TX_SEL] ? overflow : t1_tick;
			p0_rx_q <= ctl_q[TTCR_CTL_RX_SEL] ? overflow : t1_tick;
			p1_tx_q <= pwr_q[TTCR_PWR_TX1_SEL] ? overflow : t1_tick;
			p1_rx_q <= pwr_q[TTCR_PWR_RX1_SEL] ? overflow : t1_tick;
			ovf_q   <= overflow;
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign port0_tx_baud  = p0_tx_q;
	assign port0_rx_baud  = p0_rx_q;
	assign port1_tx_baud  = p1_tx_q;
	assign port1_rx_baud  = p1_rx_q;
	assign overflow_pulse = ovf_q;

endmodule : ttcr_top
